// >>> inc/ext_irq_pkg.sv
// constants and carrier types for the external interrupt controller
package ext_irq_pkg;

   // register map, byte addresses on the avalon slave
   localparam int unsigned    ADDR_W          = 4;
   localparam logic [3:0]     OFS_STATUS_CTRL = 4'h0;
   localparam logic [3:0]     OFS_CPU_STATUS  = 4'h4;

   // ext_irq_status_control field positions
   localparam int unsigned    BIT_ENABLE      = 7;
   localparam int unsigned    BIT_OSC_HI      = 4;
   localparam int unsigned    BIT_OSC_LO      = 3;
   localparam int unsigned    BIT_PENDING     = 1;
   localparam int unsigned    BIT_FLAG_CLEAR  = 0;
   localparam logic [7:0]     STATUS_CTRL_RST = 8'h90;

   // cpu status register field positions
   localparam int unsigned    BIT_MASK        = 0;
   localparam int unsigned    BIT_BUSY        = 1;
   localparam int unsigned    BIT_EXT_ARMED   = 2;

   // port pins that may serve as extra interrupt sources
   localparam int unsigned    PORT_PINS       = 4;
   localparam int unsigned    SYNC_STAGES     = 2;

   // vectors, highest priority first for the lower sources
   localparam int unsigned    OTHER_SRC       = 4;
   localparam logic [15:0]    VEC_TRAP        = 16'h1ffc;
   localparam logic [15:0]    VEC_EXT         = 16'h1ffa;
   localparam logic [15:0]    VEC_OTHER [OTHER_SRC] = '{
      16'h1ff8, 16'h1ff6, 16'h1ff4, 16'h1ff2
   };

   // cpu registers in stacking order; unstacking runs backwards
   typedef enum logic [2:0] {
      REG_PC_LO,
      REG_PC_HI,
      REG_INDEX,
      REG_ACC,
      REG_CCR
   } cpu_reg_type;

   localparam logic [2:0]     STACK_LAST      = 3'h4;

   // per-instruction status from the cpu core
   typedef struct packed {
      logic instr_end;
      logic trap_exec;
      logic return_exec;
      logic mask_set;
      logic mask_clear;
      logic pulled_mask;
   } cpu_cmd_type;

   // sequencer commands toward the cpu core
   typedef struct packed {
      logic        busy;
      logic        stack_push;
      logic        stack_pull;
      cpu_reg_type stack_reg;
      logic        vector_fetch;
      logic [15:0] vector_addr;
      logic        seq_done;
      logic        global_mask;
   } seq_out_type;

   // oscillator controls
   typedef struct packed {
      logic use_external;
      logic low_power_osc_en;
      logic ext_pin_osc_en;
   } osc_ctrl_type;

endpackage

// >>> hdl/ext_irq_sync.sv
// multi-bit two stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns
`default_nettype none

module ext_irq_sync
#(
   parameter int unsigned WIDTH    = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
   input  wire logic             mclk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] pin_in,
   output var  logic [WIDTH-1:0] pin_sync
);

   logic [WIDTH-1:0] meta_r;

   // the first stage feeds only the second stage
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_r   <= RST_VAL;
         pin_sync <= RST_VAL;
      end
      else
      begin
         meta_r   <= pin_in;
         pin_sync <= meta_r;
      end
   end

endmodule
`default_nettype wire

// >>> hdl/ext_irq_ctrl.sv
// external interrupt latch, status/control register and cpu entry sequencer
`timescale 1ns/1ns
`default_nettype none

module ext_irq_ctrl
(
   input  wire logic                          mclk,
   input  wire logic                          rst_b,
   // avalon-mm slave
   input  wire logic [ext_irq_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [31:0]                   avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output var  logic [31:0]                   avs_readdata,
   output var  logic                          avs_waitrequest,
   // pins
   input  wire logic                          irq_pin_b,
   input  wire logic [ext_irq_pkg::PORT_PINS-1:0] port_int_pins,
   // nonvolatile option bits
   input  wire logic                          port_int_option,
   input  wire logic                          level_sense_option,
   // cpu side
   input  wire logic [ext_irq_pkg::OTHER_SRC-1:0] other_irq_req,
   input  wire ext_irq_pkg::cpu_cmd_type      cpu_cmd,
   output var  ext_irq_pkg::seq_out_type      seq_out,
   output var  ext_irq_pkg::osc_ctrl_type     osc_ctrl,
   output var  logic                          ext_int_request
);

   typedef enum logic [2:0] {
      SEQ_IDLE,
      SEQ_PUSH,
      SEQ_MASK,
      SEQ_VEC_HI,
      SEQ_VEC_LO,
      SEQ_PULL
   } seq_state_type;

   // synchronised pins
   logic                                  irq_s_b;
   logic [ext_irq_pkg::PORT_PINS-1:0]     port_s;

   // detection state
   logic                                  node_prev_r;
   logic                                  node_prev_nxt;
   logic                                  node_active;
   logic                                  set_req;

   // status and control register
   logic                                  enable_r;
   logic                                  enable_nxt;
   logic                                  osc_lo_r;
   logic                                  osc_lo_nxt;
   logic                                  osc_hi_r;
   logic                                  osc_hi_nxt;
   logic                                  pending_r;
   logic                                  pending_nxt;

   // bus slave
   logic                                  ack_r;
   logic                                  ack_nxt;
   logic [31:0]                           rdata_r;
   logic [31:0]                           rdata_nxt;
   logic                                  wr_take;
   logic                                  wr_clear;

   // sequencer
   seq_state_type                         state_r;
   seq_state_type                         state_nxt;
   logic [2:0]                            cnt_r;
   logic [2:0]                            cnt_nxt;
   logic [15:0]                           vec_r;
   logic [15:0]                           vec_nxt;
   logic                                  mask_r;
   logic                                  mask_nxt;
   logic                                  fetch_clear;

   // pin synchronisers; idle levels are pin high, port pins low
   ext_irq_sync
   #(
      .WIDTH   (1),
      .RST_VAL (1'b1)
   )
   u_sync_irq
   (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .pin_in   (irq_pin_b),
      .pin_sync (irq_s_b)
   );

   ext_irq_sync
   #(
      .WIDTH   (ext_irq_pkg::PORT_PINS),
      .RST_VAL ('0)
   )
   u_sync_port
   (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .pin_in   (port_int_pins),
      .pin_sync (port_s)
   );

   // all sources meet on one wired node, as in the pad logic: a held
   // port pin or a held low pin hides every other source's edges
   always_comb
   begin
      node_active   = (port_int_option && (|port_s)) || !irq_s_b;
      node_prev_nxt = node_active;
      // an edge needs the node to go inactive first
      set_req       = (node_active && !node_prev_r)
                   || (level_sense_option && node_active);
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         node_prev_r <= 1'b0;
      end
      else
      begin
         node_prev_r <= node_prev_nxt;
      end
   end

   // avalon slave: one wait cycle, then the access completes
   assign wr_take         = avs_write && ack_r;
   assign wr_clear        = wr_take
                          && (avs_address == ext_irq_pkg::OFS_STATUS_CTRL)
                          && avs_byteenable[0]
                          && avs_writedata[ext_irq_pkg::BIT_FLAG_CLEAR];
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign avs_readdata    = rdata_r;

   always_comb
   begin
      ack_nxt   = (avs_read || avs_write) && !ack_r;
      rdata_nxt = 32'h0000_0000;
      if (avs_read && !ack_r)
      begin
         case (avs_address)
            ext_irq_pkg::OFS_STATUS_CTRL:
            begin
               rdata_nxt[ext_irq_pkg::BIT_ENABLE]  = enable_r;
               rdata_nxt[ext_irq_pkg::BIT_OSC_HI]  = osc_hi_r;
               rdata_nxt[ext_irq_pkg::BIT_OSC_LO]  = osc_lo_r;
               rdata_nxt[ext_irq_pkg::BIT_PENDING] = pending_r;
            end
            ext_irq_pkg::OFS_CPU_STATUS:
            begin
               rdata_nxt[ext_irq_pkg::BIT_MASK]      = mask_r;
               rdata_nxt[ext_irq_pkg::BIT_BUSY]      = (state_r != SEQ_IDLE);
               rdata_nxt[ext_irq_pkg::BIT_EXT_ARMED] = ext_int_request;
            end
            default:
            begin
               rdata_nxt = 32'h0000_0000;
            end
         endcase
      end
   end

   always_comb
   begin
      enable_nxt = enable_r;
      osc_lo_nxt = osc_lo_r;
      osc_hi_nxt = osc_hi_r;
      if (wr_take && (avs_address == ext_irq_pkg::OFS_STATUS_CTRL)
          && avs_byteenable[0])
      begin
         enable_nxt = avs_writedata[ext_irq_pkg::BIT_ENABLE];
         osc_lo_nxt = avs_writedata[ext_irq_pkg::BIT_OSC_LO];
         osc_hi_nxt = avs_writedata[ext_irq_pkg::BIT_OSC_HI];
      end
      // a new request in the clearing cycle is kept
      if (set_req)
      begin
         pending_nxt = 1'b1;
      end
      else if (wr_clear || fetch_clear)
      begin
         pending_nxt = 1'b0;
      end
      else
      begin
         pending_nxt = pending_r;
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ack_r     <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         enable_r  <= ext_irq_pkg::STATUS_CTRL_RST[ext_irq_pkg::BIT_ENABLE];
         osc_hi_r  <= ext_irq_pkg::STATUS_CTRL_RST[ext_irq_pkg::BIT_OSC_HI];
         osc_lo_r  <= ext_irq_pkg::STATUS_CTRL_RST[ext_irq_pkg::BIT_OSC_LO];
         pending_r <= ext_irq_pkg::STATUS_CTRL_RST[ext_irq_pkg::BIT_PENDING];
      end
      else
      begin
         ack_r     <= ack_nxt;
         rdata_r   <= rdata_nxt;
         enable_r  <= enable_nxt;
         osc_hi_r  <= osc_hi_nxt;
         osc_lo_r  <= osc_lo_nxt;
         pending_r <= pending_nxt;
      end
   end

   // oscillator selection; the external one is enabled whenever the low
   // select is set so it can settle before software drops the high select
   always_comb
   begin
      osc_ctrl.use_external     = osc_lo_r && !osc_hi_r;
      osc_ctrl.low_power_osc_en = !(osc_lo_r && !osc_hi_r);
      osc_ctrl.ext_pin_osc_en   = osc_lo_r;
   end

   assign ext_int_request = pending_r && enable_r && !mask_r;

   // lower priority sources: index zero wins
   function automatic logic [15:0] other_vector
   (
      input logic [ext_irq_pkg::OTHER_SRC-1:0] req
   );
      logic [15:0] v;
      v = ext_irq_pkg::VEC_OTHER[0];
      for (int i = ext_irq_pkg::OTHER_SRC - 1; i >= 0; i--)
      begin
         if (req[i])
         begin
            v = ext_irq_pkg::VEC_OTHER[i];
         end
      end
      return v;
   endfunction

   always_comb
   begin
      state_nxt   = state_r;
      cnt_nxt     = cnt_r;
      vec_nxt     = vec_r;
      mask_nxt    = mask_r;
      fetch_clear = 1'b0;
      case (state_r)
         SEQ_IDLE:
         begin
            if (cpu_cmd.mask_set)
            begin
               mask_nxt = 1'b1;
            end
            else if (cpu_cmd.mask_clear)
            begin
               mask_nxt = 1'b0;
            end
            if (cpu_cmd.instr_end)
            begin
               if (cpu_cmd.return_exec)
               begin
                  state_nxt = SEQ_PULL;
                  cnt_nxt   = ext_irq_pkg::STACK_LAST;
               end
               else if (cpu_cmd.trap_exec)
               begin
                  vec_nxt   = ext_irq_pkg::VEC_TRAP;
                  state_nxt = SEQ_PUSH;
                  cnt_nxt   = 3'h0;
               end
               else if (ext_int_request)
               begin
                  vec_nxt   = ext_irq_pkg::VEC_EXT;
                  state_nxt = SEQ_PUSH;
                  cnt_nxt   = 3'h0;
               end
               else if (!mask_r && (|other_irq_req))
               begin
                  vec_nxt   = other_vector(other_irq_req);
                  state_nxt = SEQ_PUSH;
                  cnt_nxt   = 3'h0;
               end
            end
         end
         SEQ_PUSH:
         begin
            if (cnt_r == ext_irq_pkg::STACK_LAST)
            begin
               state_nxt = SEQ_MASK;
            end
            else
            begin
               cnt_nxt = cnt_r + 3'h1;
            end
         end
         SEQ_MASK:
         begin
            mask_nxt  = 1'b1;
            state_nxt = SEQ_VEC_HI;
         end
         SEQ_VEC_HI:
         begin
            fetch_clear = (vec_r == ext_irq_pkg::VEC_EXT);
            state_nxt   = SEQ_VEC_LO;
         end
         SEQ_VEC_LO:
         begin
            state_nxt = SEQ_IDLE;
         end
         SEQ_PULL:
         begin
            // clearing the mask here lets a held request re-enter at once
            if (cnt_r == 3'(ext_irq_pkg::REG_CCR))
            begin
               mask_nxt = cpu_cmd.pulled_mask;
            end
            if (cnt_r == 3'h0)
            begin
               state_nxt = SEQ_IDLE;
            end
            else
            begin
               cnt_nxt = cnt_r - 3'h1;
            end
         end
         default:
         begin
            state_nxt = SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r <= SEQ_IDLE;
         cnt_r   <= 3'h0;
         vec_r   <= 16'h0000;
         mask_r  <= 1'b1;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         vec_r   <= vec_nxt;
         mask_r  <= mask_nxt;
      end
   end

   always_comb
   begin
      seq_out.busy         = (state_r != SEQ_IDLE);
      seq_out.stack_push   = (state_r == SEQ_PUSH);
      seq_out.stack_pull   = (state_r == SEQ_PULL);
      seq_out.stack_reg    = ext_irq_pkg::cpu_reg_type'(cnt_r);
      seq_out.vector_fetch = (state_r == SEQ_VEC_HI) || (state_r == SEQ_VEC_LO);
      seq_out.vector_addr  = (state_r == SEQ_VEC_LO) ? (vec_r | 16'h0001) : vec_r;
      seq_out.seq_done     = (state_r == SEQ_VEC_LO)
                          || ((state_r == SEQ_PULL) && (cnt_r == 3'h0));
      seq_out.global_mask  = mask_r;
   end

endmodule
`default_nettype wire

// >>> testbench/ext_irq_ctrl_props.sv
// concurrent checks on the external interrupt controller ports
`timescale 1ns/1ns
`default_nettype none

module ext_irq_ctrl_props
(
   input wire logic                               mclk,
   input wire logic                               rst_b,
   input wire logic                               avs_read,
   input wire logic                               avs_write,
   input wire logic                               avs_waitrequest,
   input wire logic [ext_irq_pkg::OTHER_SRC-1:0]  other_irq_req,
   input wire ext_irq_pkg::cpu_cmd_type           cpu_cmd,
   input wire ext_irq_pkg::seq_out_type           seq_out,
   input wire ext_irq_pkg::osc_ctrl_type          osc_ctrl,
   input wire logic                               ext_int_request
);
   logic go;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   // an accepted instruction end that is not a return
   assign go = cpu_cmd.instr_end && !seq_out.busy && !cpu_cmd.return_exec;

   bus_one_wait_a: assert property ($rose(avs_read || avs_write)
      |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not after one wait cycle");
   mask_blocks_a: assert property (seq_out.global_mask |-> !ext_int_request)
      else $error("external request shown while masked");
   ext_entry_a: assert property (go && !cpu_cmd.trap_exec && ext_int_request
      |-> ##7 (seq_out.vector_fetch && seq_out.vector_addr == ext_irq_pkg::VEC_EXT))
      else $error("external entry did not fetch its vector");
   trap_entry_a: assert property (go && cpu_cmd.trap_exec
      |-> ##7 (seq_out.vector_addr == ext_irq_pkg::VEC_TRAP))
      else $error("trap entry did not fetch its vector");
   stack_order_a: assert property (go && (cpu_cmd.trap_exec || ext_int_request)
      |=> seq_out.stack_push && seq_out.stack_reg == ext_irq_pkg::REG_PC_LO
      ##1 seq_out.stack_reg == ext_irq_pkg::REG_PC_HI
      ##1 seq_out.stack_reg == ext_irq_pkg::REG_INDEX
      ##1 seq_out.stack_reg == ext_irq_pkg::REG_ACC
      ##1 seq_out.stack_push && seq_out.stack_reg == ext_irq_pkg::REG_CCR
      ##2 seq_out.global_mask)
      else $error("entry stacking order or mask wrong");
   unstack_order_a: assert property (cpu_cmd.instr_end && !seq_out.busy
      && cpu_cmd.return_exec
      |=> seq_out.stack_pull && seq_out.stack_reg == ext_irq_pkg::REG_CCR
      ##1 seq_out.stack_reg == ext_irq_pkg::REG_ACC
      ##1 seq_out.stack_reg == ext_irq_pkg::REG_INDEX
      ##1 seq_out.stack_reg == ext_irq_pkg::REG_PC_HI
      ##1 seq_out.stack_pull && seq_out.stack_reg == ext_irq_pkg::REG_PC_LO)
      else $error("return unstacking order wrong");
   other_prio_a: assert property (go && !cpu_cmd.trap_exec && !ext_int_request
      && !seq_out.global_mask && other_irq_req[0]
      |-> ##7 (seq_out.vector_addr == ext_irq_pkg::VEC_OTHER[0]))
      else $error("highest other source not fetched first");
   osc_ext_a: assert property (osc_ctrl.use_external
      |-> !osc_ctrl.low_power_osc_en && osc_ctrl.ext_pin_osc_en)
      else $error("external clock selected with wrong enables");
   osc_int_a: assert property (!osc_ctrl.use_external |-> osc_ctrl.low_power_osc_en)
      else $error("internal oscillator off while it clocks");
   reset_state_a: assert property ($rose(rst_b) |-> seq_out.global_mask
      && !seq_out.busy && !osc_ctrl.use_external && !osc_ctrl.ext_pin_osc_en)
      else $error("state after reset wrong");

   ext_entry_c: cover property (go && ext_int_request);
   trap_entry_c: cover property (go && cpu_cmd.trap_exec);
   return_c: cover property (cpu_cmd.instr_end && cpu_cmd.return_exec);
endmodule

bind ext_irq_ctrl ext_irq_ctrl_props u_props
(
   .mclk            (mclk),
   .rst_b           (rst_b),
   .avs_read        (avs_read),
   .avs_write       (avs_write),
   .avs_waitrequest (avs_waitrequest),
   .other_irq_req   (other_irq_req),
   .cpu_cmd         (cpu_cmd),
   .seq_out         (seq_out),
   .osc_ctrl        (osc_ctrl),
   .ext_int_request (ext_int_request)
);

`default_nettype wire

// >>> testbench/irq_src_model.sv
// pin-side model: wired-or sources on the interrupt pin, one driver per port line
`timescale 1ns/1ns
`default_nettype none

module irq_src_model
(
   input  wire logic       mclk,
   input  wire logic [1:0] pin_pull_low,
   input  wire logic [3:0] port_drive,
   output var  logic       irq_pin_b,
   output var  logic [3:0] port_int_pins
);
   // released pin sits at its pull-up level, released port lines at pull-down
   always_ff @(posedge mclk)
   begin
      irq_pin_b     <= ~|pin_pull_low;
      port_int_pins <= port_drive;
   end
endmodule

`default_nettype wire

// >>> testbench/tb_ext_irq_ctrl.sv
// self-checking bench for the external interrupt controller
`timescale 1ns/1ns
`default_nettype none

module tb_ext_irq_ctrl;
   logic                       mclk, rst_b, avs_read, avs_write;
   logic [3:0]                 avs_address, pd, oth, port_pins;
   logic [31:0]                avs_writedata, avs_readdata, q;
   logic                       avs_waitrequest, irq_pin_b, popt, lvl, req;
   logic [1:0]                 pl;
   ext_irq_pkg::cpu_cmd_type   cmd;
   ext_irq_pkg::seq_out_type   sq;
   ext_irq_pkg::osc_ctrl_type  osc;
   int                         fails, num_checks;

   ext_irq_ctrl u_dut (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .irq_pin_b(irq_pin_b), .port_int_pins(port_pins),
      .port_int_option(popt), .level_sense_option(lvl),
      .other_irq_req(oth), .cpu_cmd(cmd), .seq_out(sq), .osc_ctrl(osc),
      .ext_int_request(req));

   irq_src_model u_src (.mclk(mclk), .pin_pull_low(pl), .port_drive(pd),
      .irq_pin_b(irq_pin_b), .port_int_pins(port_pins));

   always #20 mclk = ~mclk;

   task automatic close_out();
      if (fails == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic bad(input int tmo);
      fails++;
      $display("BAD %0t wait ran out", $time);
      close_out();
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
      int n;
      avs_address <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0 && n < 20)
      begin
         n++;
         @(posedge mclk);
      end
      if (avs_waitrequest !== 1'b0)
         bad(n);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      num_checks++;
      if (q !== {24'h00_0000, e})
      begin
         fails++;
         $display("BAD %0t read %h got %h exp %h", $time, a, q, e);
      end
   endtask

   task automatic chk_osc(input logic [2:0] e);
      num_checks++;
      if (osc !== e)
      begin
         fails++;
         $display("BAD %0t oscillator controls %h exp %h", $time, osc, e);
      end
   endtask

   task automatic mask(input logic set);
      cmd <= {3'h0, set, !set, 1'b0};
      @(posedge mclk);
      cmd <= '0;
      @(posedge mclk);
   endtask

   // one instruction end, then wait for the sequencer to finish
   task automatic instr(input logic ret, input logic trap, input logic pm);
      int n;
      cmd <= {1'b1, trap, ret, 2'h0, pm};
      @(posedge mclk);
      cmd <= {5'h00, pm};
      n = 0;
      @(negedge mclk);
      while (sq.seq_done !== 1'b1 && n < 30)
      begin
         n++;
         @(negedge mclk);
      end
      if (n == 30)
         bad(n);
      cyc(2);
   endtask

   initial
   begin
      mclk = 0; rst_b = 0; avs_read = 0; avs_write = 0; avs_address = '0;
      avs_writedata = '0; cmd = '0; pl = '0; pd = '0; popt = 0; lvl = 0;
      oth = '0; fails = 0; num_checks = 0;
      cyc(8);
      rst_b <= 1'b1;
      cyc(1);
      rd(4'h0, 8'h90);
      rd(4'h4, 8'h01);
      rd(4'h8, 8'h00);
      chk_osc(3'h2);
      bus(1'b1, 4'h0, 8'h18); rd(4'h0, 8'h18); chk_osc(3'h3);
      bus(1'b1, 4'h0, 8'h08); chk_osc(3'h5);
      bus(1'b1, 4'h0, 8'hfe); rd(4'h0, 8'h98);
      bus(1'b1, 4'h0, 8'h90); mask(1'b0); rd(4'h4, 8'h00);
      pl <= 2'h1; cyc(5); rd(4'h0, 8'h92); rd(4'h4, 8'h04);
      bus(1'b1, 4'h0, 8'h91); rd(4'h0, 8'h90);
      pl <= 2'h0; cyc(5); pl <= 2'h2; cyc(5); rd(4'h0, 8'h92);
      oth <= 4'h2; instr(1'b0, 1'b0, 1'b0); oth <= 4'h0;
      rd(4'h0, 8'h90); rd(4'h4, 8'h01);
      pl <= 2'h0; cyc(5); pl <= 2'h1; cyc(5);
      rd(4'h0, 8'h92); rd(4'h4, 8'h01);
      instr(1'b1, 1'b0, 1'b0); rd(4'h4, 8'h04);
      bus(1'b1, 4'h0, 8'h91); oth <= 4'h3;
      instr(1'b0, 1'b0, 1'b0); oth <= 4'h0;
      instr(1'b1, 1'b0, 1'b0);
      lvl <= 1'b1; bus(1'b1, 4'h0, 8'h91); cyc(4); rd(4'h0, 8'h92);
      pl <= 2'h0; cyc(5); bus(1'b1, 4'h0, 8'h91); rd(4'h0, 8'h90);
      bus(1'b1, 4'h0, 8'h10); pl <= 2'h1; cyc(5);
      rd(4'h0, 8'h12); rd(4'h4, 8'h00);
      pl <= 2'h0; lvl <= 1'b0; popt <= 1'b1; cyc(5);
      bus(1'b1, 4'h0, 8'h91); pd <= 4'h4; cyc(5); rd(4'h0, 8'h92);
      bus(1'b1, 4'h0, 8'h91); pl <= 2'h1; cyc(5); rd(4'h0, 8'h90);
      pd <= 4'h0; cyc(5); pd <= 4'h1; cyc(5); rd(4'h0, 8'h90);
      pl <= 2'h0; pd <= 4'h0; cyc(5); pd <= 4'h8; cyc(5);
      rd(4'h0, 8'h92);
      bus(1'b1, 4'h0, 8'h91); popt <= 1'b0; pd <= 4'h0; cyc(5);
      pd <= 4'h2; cyc(5); rd(4'h0, 8'h90);
      popt <= 1'b1; lvl <= 1'b1; cyc(5); rd(4'h0, 8'h92);
      pd <= 4'h0; mask(1'b1); instr(1'b0, 1'b1, 1'b0);
      rd(4'h4, 8'h01); instr(1'b1, 1'b0, 1'b1);
      rst_b <= 1'b0; cyc(2); rst_b <= 1'b1; cyc(1);
      rd(4'h0, 8'h90);
      close_out();
   end
endmodule

`default_nettype wire
